// *** sim/test_telemetry_recorder_alarms.sv ***
// Purpose: self-checking bench of the telemetry recorder
// Assumes: inputs change on the falling clock edge
// Notes:   short tick, long-press and alternation counts
`timescale 1ns/1ps
module test_telemetry_recorder_alarms import tra_pkg::*; ;
  logic clk = 1'b0, sys_rst = 1'b1, sample_valid = 1'b0, cmd_erase = 1'b0;
  logic cmd_restore = 1'b0, key_right = 1'b0, cfg_we = 1'b0;
  tra_sample_t sample = '0;
  tra_cfg_t    cfg_wdata = '0, cfg;
  tra_rec_t    rec;
  logic recording, disp_alarm, disp_star, tone_valid, tone_attn, tone_ready;
  logic [3:0] alarm;
  logic [6:0] tone_code, pair_code;
  logic [7:0] pairs, p0;
  int miscompares = 0, check_count = 0;
  always #12.5 clk = ~clk;
  tra_recorder #(.TICK_CYC(20), .LONG_CYC(8), .ALT_CYC(10)) tra_recorder_inst (
    .clk(clk), .sys_rst(sys_rst), .sample_valid(sample_valid),
    .sample(sample), .cmd_erase(cmd_erase), .cmd_restore(cmd_restore),
    .key_right(key_right), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
    .cfg(cfg), .rec(rec), .recording(recording), .alarm(alarm),
    .disp_alarm(disp_alarm), .disp_star(disp_star), .tone_valid(tone_valid),
    .tone_attn(tone_attn), .tone_code(tone_code), .tone_ready(tone_ready));
  tra_tone_rx tra_tone_rx_inst (.clk(clk), .tone_valid(tone_valid),
    .tone_attn(tone_attn), .tone_code(tone_code), .tone_ready(tone_ready),
    .pair_code(pair_code), .pairs(pairs));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task smp(input logic [15:0] v, input logic [15:0] c, input logic [11:0] t);
    sample = '{v, c, t};
    pulse(sample_valid);
  endtask : smp
  task setc(input logic [15:0] tr, input logic [15:0] vl,
            input logic [15:0] il, input logic [31:0] cl,
            input logic [3:0] en, input logic au);
    cfg_wdata = '{tr, vl, il, cl, en, au};
    pulse(cfg_we);
  endtask : setc
  task row(input logic [15:0] v, input logic [15:0] c,
           input logic [11:0] t, input logic [3:0] exp);
    smp(v, c, t);
    chk(16'(alarm), 16'(exp));
  endtask : row
  task tone_for(input logic [3:0] en, input logic [15:0] v,
                input logic [15:0] c, input logic [11:0] t);
    setc(16'h03E8, 16'h03E8, 16'h01F4, 32'h0000_0000, en, 1'b1);
    smp(v, c, t);
    p0 = pairs;
    for (int i = 0; i < 150 && pairs < p0 + 8'h02; i++)
      tick(1);
  endtask : tone_for
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_settings;
    setc(16'h0064, 16'h03E8, 16'h01F4, 32'h0000_0010, 4'hF, 1'b0);
    chk(cfg.trig, 16'h0064);
    chk(16'(cfg.alarm_en), 16'h000F);
    pulse(cmd_restore);
    chk(cfg.trig, TRA_DEF_TRIG);
    chk(16'({cfg.alarm_en, cfg.auto_erase}), 16'({TRA_DEF_EN, TRA_DEF_AUTO}));
    chk(16'(disp_star), 16'h0000);
    $display("test settings done");
  endtask : t_settings
  task t_session;
    smp(16'h04B0, 16'h0064, 12'h0FA);
    chk(16'(recording), 16'h0001);
    smp(16'h04B0, 16'h0064, 12'h0FA);
    smp(16'h03E8, 16'h01F4, 12'h190);
    smp(16'h0578, 16'h012C, 12'h0C8);
    chk(rec.volt_min, 16'h03E8);
    chk(rec.volt_max, 16'h0578);
    chk(rec.curr_peak, 16'h01F4);
    chk(16'(rec.curr_avg >= 16'h0064 && rec.curr_avg <= 16'h01F4), 16'h0001);
    chk(16'(rec.temp_min), 16'h00C8);
    chk(16'(rec.temp_max), 16'h0190);
    $display("test session done");
  endtask : t_session
  task t_previous;
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(1);
    setc(16'h03E8, 16'h0000, 16'h0000, 32'h0000_0000, 4'h0, 1'b1);
    smp(16'h0384, 16'h0032, 12'h0C8);
    chk(16'(recording), 16'h0000);
    chk(rec.volt_min, 16'h03E8);
    smp(16'h044C, 16'h07D0, 12'h0C8);
    chk(16'(recording), 16'h0001);
    smp(16'h0384, 16'h09C4, 12'h0C8);
    chk(rec.volt_max, 16'h0384);
    chk(rec.curr_peak, 16'h09C4);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(1);
    setc(16'h03E8, 16'h0000, 16'h0000, 32'h0000_0000, 4'h0, 1'b0);
    smp(16'h03E8, 16'h07D0, 12'h0C8);
    smp(16'h05DC, 16'h07D0, 12'h0C8);
    chk(rec.volt_min, 16'h0384);
    chk(rec.volt_max, 16'h05DC);
    $display("test previous session done");
  endtask : t_previous
  task t_alarms;
    setc(16'h03E8, 16'h03E8, 16'h01F4, 32'hFFFF_FFFF, 4'hB, 1'b1);
    row(16'h0384, 16'h0064, 12'h0C8, 4'h1);
    row(16'h044C, 16'h0258, 12'h0C8, 4'h2);
    row(16'h044C, 16'h0190, 12'h0C8, 4'h0);
    row(16'h044C, 16'h0064, 12'h360, 4'h8);
    row(16'h044C, 16'h0064, 12'h352, 4'h0);
    setc(16'h03E8, 16'h03E8, 16'h01F4, 32'h0000_0000, 4'h0, 1'b1);
    row(16'h0384, 16'h0258, 12'h360, 4'h0);
    chk(16'(disp_alarm), 16'h0000);
    tone_for(4'h1, 16'h0384, 16'h0064, 12'h0C8);
    chk(16'(pair_code), 16'(TRA_MORSE_V));
    tone_for(4'h2, 16'h044C, 16'h0258, 12'h0C8);
    chk(16'(pair_code), 16'(TRA_MORSE_I));
    tone_for(4'h4, 16'h044C, 16'h0064, 12'h0C8);
    chk(16'(alarm), 16'h0004);
    chk(16'(pair_code), 16'(TRA_MORSE_C));
    tone_for(4'h8, 16'h044C, 16'h0064, 12'h360);
    chk(16'(pair_code), 16'(TRA_MORSE_T));
    $display("test alarms done");
  endtask : t_alarms
  task t_erase;
    pulse(cmd_erase);
    chk(rec.volt_max, 16'h0000);
    chk(rec.capacity[15:0], 16'h0000);
    smp(16'h044C, 16'h0100, 12'h0C8);
    tick(60);
    chk(rec.run_time[15:0], 16'h0000);
    // 61 edges after the fresh load hold three or four ticks of 20 cycles
    chk(16'(rec.capacity inside {32'h0000_0300, 32'h0000_0400}), 16'h0001);
    smp(16'h044C, 16'h07D0, 12'h0C8);
    tick(42);
    chk(16'(rec.run_time != 32'h0000_0000), 16'h0001);
    key_right = 1'b1;
    tick(10);
    key_right = 1'b0;
    tick(2);
    chk(16'(disp_star), 16'h0001);
    chk(rec.volt_max, 16'h0000);
    $display("test erase done");
  endtask : t_erase
  initial begin
    tick(10);
    sys_rst = 1'b0;
    tick(1);
    t_settings();
    t_session();
    t_previous();
    t_alarms();
    t_erase();
    summarize();
  end
  // budget well above the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule : test_telemetry_recorder_alarms
bind tra_recorder tra_recorder_asserts #(.LONG_CYC(LONG_CYC))
  tra_recorder_asserts_inst (.clk(clk), .sys_rst(sys_rst),
  .sample_valid(sample_valid), .sample(sample), .cmd_erase(cmd_erase),
  .cmd_restore(cmd_restore), .key_right(key_right), .cfg(cfg), .rec(rec),
  .recording(recording), .alarm(alarm), .disp_star(disp_star),
  .tone_valid(tone_valid), .tone_attn(tone_attn), .tone_code(tone_code),
  .tone_ready(tone_ready));

// *** sim/tra_recorder_asserts.sv ***
// Purpose: port-level checks of the telemetry recorder
// Assumes: one clock, sys_rst synchronous active high
// Notes:   LONG_CYC is handed on by the bind
`timescale 1ns/1ps
module tra_recorder_asserts import tra_pkg::*; #(
  parameter int LONG_CYC = 8
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // inputs of the recorder
  input wire logic        sample_valid,
  input wire tra_sample_t sample,
  input wire logic        cmd_erase,
  input wire logic        cmd_restore,
  input wire logic        key_right,
  // outputs of the recorder, then its tone_ready input
  input wire tra_cfg_t    cfg,
  input wire tra_rec_t    rec,
  input wire logic        recording,
  input wire logic [3:0]  alarm,
  input wire logic        disp_star,
  input wire logic        tone_valid,
  input wire logic        tone_attn,
  input wire logic [6:0]  tone_code,
  input wire logic        tone_ready
);
  localparam tra_cfg_t DFLT = '{TRA_DEF_TRIG, TRA_DEF_VLIM, TRA_DEF_ILIM,
                                TRA_DEF_CLIM, TRA_DEF_EN, TRA_DEF_AUTO};
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // long press counter
  // ---------------------------------------------------------------
  always_comb hold_next = key_right ? hold_reg + 8'h01 : 8'h00;
  always_ff @(posedge clk) begin
    if (sys_rst)
      hold_reg <= 8'h00;
    else
      hold_reg <= hold_next;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence attn_taken;
    tone_valid && tone_attn && tone_ready;
  endsequence
  sequence code_offered;
    tone_valid && !tone_attn;
  endsequence
  chk_tone_order: assert property (attn_taken |=> code_offered)
    else $error("morse request did not follow attention tone");
  chk_tone_hold: assert property (tone_valid && !tone_ready |=>
    tone_valid && $stable(tone_code) && $stable(tone_attn))
    else $error("tone request changed before acceptance");
  chk_alarm_off: assert property (sample_valid |=>
    (alarm & ~$past(cfg.alarm_en)) == 4'h0)
    else $error("disabled alarm raised");
  chk_volt_low: assert property (sample_valid && cfg.alarm_en[TRA_AL_V]
    && sample.volt < cfg.volt_lim |=> alarm[TRA_AL_V])
    else $error("voltage alarm missing");
  chk_curr_high: assert property (sample_valid && cfg.alarm_en[TRA_AL_I]
    && sample.curr > cfg.curr_lim |=> alarm[TRA_AL_I])
    else $error("current alarm missing");
  chk_curr_clear: assert property (sample_valid
    && sample.curr < cfg.curr_lim |=> !alarm[TRA_AL_I])
    else $error("current alarm not cleared");
  chk_cap_over: assert property (sample_valid && !cmd_erase
    && cfg.alarm_en[TRA_AL_C] && rec.capacity > cfg.cap_lim
    |-> ##[1:2] alarm[TRA_AL_C])
    else $error("capacity alarm missing");
  chk_temp_hot: assert property (sample_valid && cfg.alarm_en[TRA_AL_T]
    && $signed(sample.temp) > $signed(TRA_TEMP_LIM[11:0]) |=> alarm[TRA_AL_T])
    else $error("temperature alarm missing");
  chk_restore_dflt: assert property (cmd_restore |=> cfg == DFLT)
    else $error("factory settings not loaded");
  chk_erase_zero: assert property (cmd_erase |=> rec == '0)
    else $error("records not cleared");
  chk_fast_star: assert property (hold_reg == LONG_CYC[7:0]
    |-> ##[0:2] disp_star)
    else $error("fast clear not shown");
  chk_idle_keep: assert property (!recording && !cmd_erase && !key_right
    |=> rec === $past(rec))
    else $error("records changed before trigger");
  chk_trig_start: assert property (sample_valid && (cfg.trig == 16'h0000
    || sample.curr > cfg.trig) |=> recording)
    else $error("recording did not start");
endmodule : tra_recorder_asserts

// *** sim/tra_tone_rx.sv ***
// Purpose: telemetry receiver model taking tone requests
// Assumes: accepts a request DLY+1 cycles after it is offered
// Notes:   pairs counts attention-then-morse sequences
`timescale 1ns/1ps
module tra_tone_rx import tra_pkg::*; #(
  parameter int DLY = 3
) (
  // clock
  input wire logic        clk,
  // tone link
  input wire logic        tone_valid,
  input wire logic        tone_attn,
  input wire logic [6:0]  tone_code,
  output logic            tone_ready,
  // observation
  output logic [6:0]      pair_code,
  output logic [7:0]      pairs
);
  int   wait_cnt  = 0;
  logic attn_seen = 1'b0;
  initial begin
    tone_ready = 1'b0;
    pair_code  = 7'h00;
    pairs      = 8'h00;
  end
  always @(posedge clk) begin
    if (tone_valid && tone_ready) begin
      if (tone_attn)
        attn_seen <= 1'b1;
      else if (attn_seen) begin
        pair_code <= tone_code;
        pairs     <= pairs + 8'h01;
        attn_seen <= 1'b0;
      end
    end
    // slow on purpose so the request must be held
    wait_cnt   <= (tone_valid && !tone_ready) ? wait_cnt + 1 : 0;
    tone_ready <= tone_valid && !tone_ready && wait_cnt >= DLY;
  end
endmodule : tra_tone_rx

// *** src/tra_pkg.sv ***
// Purpose: shared constants and carriers for the telemetry recorder
// Assumes: samples arrive as fixed-point words on sample_valid, temperature signed
// Notes:   widths are fixed; the top module may override only the cycle counts
package tra_pkg;

  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int TRA_VW = 16;   // voltage, 10 mV units
  localparam int TRA_IW = 16;   // current, 10 mA units
  localparam int TRA_TW = 12;   // temperature, 0.1 degC units, signed
  localparam int TRA_CW = 32;   // capacity accumulator
  localparam int TRA_RW = 32;   // run time, seconds
  localparam int TRA_CLK_HZ = 40_000_000;
  localparam int TRA_TICK_MS = 1000;
  localparam int TRA_TICK_CYC = TRA_CLK_HZ / 1000 * TRA_TICK_MS;
  localparam int TRA_LONG_MS = 2000;
  localparam int TRA_LONG_CYC = TRA_CLK_HZ / 1000 * TRA_LONG_MS;
  localparam int TRA_ALT_MS = 1000;
  localparam int TRA_ALT_CYC = TRA_CLK_HZ / 1000 * TRA_ALT_MS;
  localparam int TRA_AVG_SH = 4;   // average filter weight 1/16

  // ---------------------------------------------------------------
  // reset / factory values
  // ---------------------------------------------------------------
  localparam logic [15:0] TRA_TEMP_LIM = 16'h0352; // 85.0 degC
  localparam logic [15:0] TRA_DEF_TRIG = 16'h0000;
  localparam logic [15:0] TRA_DEF_VLIM = 16'h0000;
  localparam logic [15:0] TRA_DEF_ILIM = 16'h0000;
  localparam logic [31:0] TRA_DEF_CLIM = 32'h0000_0000;
  localparam logic [3:0]  TRA_DEF_EN   = 4'h0;  // all alarms off
  localparam logic        TRA_DEF_AUTO = 1'b1;

  // ---------------------------------------------------------------
  // alarm bit positions and morse codes
  // ---------------------------------------------------------------
  localparam int TRA_AL_V = 0;
  localparam int TRA_AL_I = 1;
  localparam int TRA_AL_C = 2;
  localparam int TRA_AL_T = 3;
  // morse: len in [6:4], symbols in [3:0] msb first, 1 = dash
  localparam logic [6:0] TRA_MORSE_V = 7'h31;  // ..-
  localparam logic [6:0] TRA_MORSE_I = 7'h30;  // ...
  localparam logic [6:0] TRA_MORSE_C = 7'h4A;  // -.-.
  localparam logic [6:0] TRA_MORSE_T = 7'h11;  // -

  typedef struct packed {
    logic [15:0] trig;       // recording threshold current
    logic [15:0] volt_lim;   // voltage alarm, falls below
    logic [15:0] curr_lim;   // current alarm, rises above
    logic [31:0] cap_lim;    // capacity alarm
    logic [3:0]  alarm_en;   // 0 = OFF per alarm
    logic        auto_erase;
  } tra_cfg_t;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [11:0] temp;
  } tra_sample_t;

  typedef struct packed {
    logic [15:0] volt_min;
    logic [15:0] volt_max;
    logic [15:0] curr_avg;
    logic [15:0] curr_peak;
    logic [31:0] capacity;
    logic [31:0] run_time;
    logic [11:0] temp_min;
    logic [11:0] temp_max;
  } tra_rec_t;

endpackage : tra_pkg

// *** src/tra_recorder.sv ***
// Purpose: battery telemetry recorder with alarm signalling
// Assumes: samples and key events come from logic on clk
// Notes:   power-up is sys_rst; stored records survive it
`timescale 1ns/1ps
module tra_recorder import tra_pkg::*; #(
  parameter int TICK_CYC = TRA_TICK_CYC,
  parameter int LONG_CYC = TRA_LONG_CYC,
  parameter int ALT_CYC  = TRA_ALT_CYC
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  // measurements
  input  wire logic        sample_valid,
  input  wire tra_sample_t sample,
  // terminal commands, one-cycle pulses; key_right is held for a long press
  input  wire logic  cmd_erase,
  input  wire logic  cmd_restore,
  input  wire logic  key_right,
  // settings write
  input  wire logic     cfg_we,
  input  wire tra_cfg_t cfg_wdata,
  // settings and records readout
  output tra_cfg_t   cfg,
  output tra_rec_t   rec,
  output logic       recording,
  // display and alarms
  output logic [3:0] alarm,
  output logic       disp_alarm,
  output logic       disp_star,
  // tone link
  output logic       tone_valid,
  output logic       tone_attn,
  output logic [6:0] tone_code,
  input  wire logic  tone_ready
);

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  localparam tra_cfg_t CFG_DEF = '{trig: TRA_DEF_TRIG,
    volt_lim: TRA_DEF_VLIM, curr_lim: TRA_DEF_ILIM, cap_lim: TRA_DEF_CLIM,
    alarm_en: TRA_DEF_EN, auto_erase: TRA_DEF_AUTO};

  tra_cfg_t cfg_reg, cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (cmd_restore)
      cfg_next = CFG_DEF;
    else if (cfg_we)
      cfg_next = cfg_wdata;
  end

  // ---------------------------------------------------------------
  // session phase and records
  // ---------------------------------------------------------------
  // records are not reset: they must outlive power-up for readout
  tra_rec_t    rec_reg, rec_next;
  logic        trig_reg, trig_next;   // threshold seen this session
  logic        live_reg, live_next;   // first sample after clear pending
  logic        above_reg, above_next;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [31:0] long_cnt_reg, long_cnt_next;
  logic        star_reg, star_next;
  logic        clr;
  logic        fast_clr;
  logic        over;
  logic [16:0] avg_sum;
  tra_rec_t    fresh;

  assign over = sample.curr > cfg_reg.trig;
  assign fast_clr = key_right && (long_cnt_reg == 32'(LONG_CYC - 1));

  always_comb begin
    fresh = '{volt_min: sample.volt, volt_max: sample.volt,
      curr_avg: sample.curr, curr_peak: sample.curr, capacity: 32'h0000_0000,
      run_time: 32'h0000_0000, temp_min: sample.temp, temp_max: sample.temp};
  end

  assign clr = cmd_erase || fast_clr;

  always_comb begin
    rec_next      = rec_reg;
    trig_next     = trig_reg;
    live_next     = live_reg;
    above_next    = above_reg;
    tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
    long_cnt_next = key_right ? long_cnt_reg + 32'h0000_0001
                              : 32'h0000_0000;
    star_next     = star_reg;
    avg_sum       = 17'h0_0000;
    if (fast_clr) begin
      star_next     = 1'b1;
      long_cnt_next = 32'h0000_0000;
    end
    if (clr) begin
      live_next = 1'b1;
      rec_next  = '0;
    end
    if (sample_valid) begin
      above_next = over;
      // a zero threshold counts as exceeded at once
      if (!trig_reg && (over || cfg_reg.trig == 16'h0000)) begin
        trig_next = 1'b1;
        // auto-erase or a zero threshold drops the old session; otherwise keep adding to it
        if (cfg_reg.auto_erase || cfg_reg.trig == 16'h0000)
          live_next = 1'b1;
      end
      if (trig_reg && !clr) begin
        if (live_reg) begin
          rec_next  = fresh;
          live_next = 1'b0;
        end else begin
          if (sample.volt < rec_reg.volt_min)
            rec_next.volt_min = sample.volt;
          if (sample.volt > rec_reg.volt_max)
            rec_next.volt_max = sample.volt;
          if (sample.curr > rec_reg.curr_peak)
            rec_next.curr_peak = sample.curr;
          avg_sum = {1'b0, rec_reg.curr_avg}
                  - {1'b0, rec_reg.curr_avg >> TRA_AVG_SH}
                  + {1'b0, sample.curr >> TRA_AVG_SH};
          rec_next.curr_avg = avg_sum[15:0];
          if ($signed(sample.temp) < $signed(rec_reg.temp_min))
            rec_next.temp_min = sample.temp;
          if ($signed(sample.temp) > $signed(rec_reg.temp_max))
            rec_next.temp_max = sample.temp;
        end
      end
    end
    if (tick_cnt_reg == 32'(TICK_CYC - 1)) begin
      tick_cnt_next = 32'h0000_0000;
      if (trig_reg && !live_reg && !clr) begin
        rec_next.capacity = rec_reg.capacity
                          + {16'h0000, sample.curr};
        if (above_reg)
          rec_next.run_time = rec_reg.run_time + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // alarms
  // ---------------------------------------------------------------
  logic [3:0] al_reg, al_next;
  logic [3:0] al_raw;

  always_comb begin
    al_raw = 4'h0;
    al_raw[TRA_AL_V] = sample.volt < cfg_reg.volt_lim;
    al_raw[TRA_AL_I] = sample.curr > cfg_reg.curr_lim;
    al_raw[TRA_AL_C] = rec_reg.capacity > cfg_reg.cap_lim;
    al_raw[TRA_AL_T] = $signed(sample.temp) >
                       $signed(TRA_TEMP_LIM[11:0]);
    al_next = al_reg;
    if (sample_valid)
      al_next = al_raw & cfg_reg.alarm_en;
    else
      al_next[TRA_AL_C] = al_raw[TRA_AL_C] & cfg_reg.alarm_en[TRA_AL_C];
  end

  // ---------------------------------------------------------------
  // display alternation and tone requests
  // ---------------------------------------------------------------
  logic [31:0] alt_cnt_reg, alt_cnt_next;
  logic        alt_reg, alt_next;
  logic [1:0]  sel_reg, sel_next;
  logic        tone_start;
  logic        tone_busy;
  logic [6:0]  sel_code;

  always_comb begin
    case (sel_reg)
      2'd0:    sel_code = TRA_MORSE_V;
      2'd1:    sel_code = TRA_MORSE_I;
      2'd2:    sel_code = TRA_MORSE_C;
      default: sel_code = TRA_MORSE_T;
    endcase
  end

  // one alarm is announced per display period, rotating through active ones
  assign tone_start = alt_next && !alt_reg && al_reg[sel_reg] && !tone_busy;

  always_comb begin
    alt_cnt_next = alt_cnt_reg + 32'h0000_0001;
    alt_next     = alt_reg;
    sel_next     = sel_reg;
    if (al_reg == 4'h0) begin
      alt_cnt_next = 32'h0000_0000;
      alt_next     = 1'b0;
    end else if (alt_cnt_reg == 32'(ALT_CYC - 1)) begin
      alt_cnt_next = 32'h0000_0000;
      alt_next     = !alt_reg;
    end
    if (!al_reg[sel_reg] || (alt_reg && !alt_next))
      sel_next = sel_reg + 2'd1;
  end

  tra_tone u_tone (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (tone_start),
    .morse      (sel_code),
    .tone_valid (tone_valid),
    .tone_attn  (tone_attn),
    .tone_code  (tone_code),
    .tone_ready (tone_ready),
    .busy       (tone_busy)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    rec_reg <= rec_next;
    if (sys_rst) begin
      cfg_reg      <= CFG_DEF;
      trig_reg     <= 1'b0;
      live_reg     <= 1'b0;
      above_reg    <= 1'b0;
      tick_cnt_reg <= 32'h0000_0000;
      long_cnt_reg <= 32'h0000_0000;
      star_reg     <= 1'b0;
      al_reg       <= 4'h0;
      alt_cnt_reg  <= 32'h0000_0000;
      alt_reg      <= 1'b0;
      sel_reg      <= 2'd0;
    end else begin
      cfg_reg      <= cfg_next;
      trig_reg     <= trig_next;
      live_reg     <= live_next;
      above_reg    <= above_next;
      tick_cnt_reg <= tick_cnt_next;
      long_cnt_reg <= long_cnt_next;
      star_reg     <= star_next;
      al_reg       <= al_next;
      alt_cnt_reg  <= alt_cnt_next;
      alt_reg      <= alt_next;
      sel_reg      <= sel_next;
    end
  end

  assign cfg        = cfg_reg;
  assign rec        = rec_reg;
  assign recording  = trig_reg;
  assign alarm      = al_reg;
  assign disp_alarm = alt_reg;
  assign disp_star  = star_reg;

endmodule : tra_recorder

// *** src/tra_tone.sv ***
// Purpose: tone request sequencer, attention tone then morse character
// Assumes: tone_ready from the link, same clock
// Notes:   one request per cycle of tone_valid/tone_ready
`timescale 1ns/1ps
module tra_tone import tra_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // request
  input  wire logic       start,
  input  wire logic [6:0] morse,
  // tone link
  output logic            tone_valid,
  output logic            tone_attn,
  output logic [6:0]      tone_code,
  input  wire logic       tone_ready,
  output logic            busy
);

  typedef enum logic [1:0] {TRA_T_IDLE, TRA_T_ATTN, TRA_T_CHAR} tra_tst_t;
  tra_tst_t   st_reg, st_next;
  logic [6:0] code_reg, code_next;

  always_comb begin
    st_next = st_reg;
    code_next = code_reg;
    case (st_reg)
      TRA_T_IDLE: begin
        if (start) begin
          st_next = TRA_T_ATTN;
          code_next = morse;
        end
      end
      TRA_T_ATTN: if (tone_ready) st_next = TRA_T_CHAR;
      TRA_T_CHAR: if (tone_ready) st_next = TRA_T_IDLE;
      default:    st_next = TRA_T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg   <= TRA_T_IDLE;
      code_reg <= 7'h00;
    end else begin
      st_reg   <= st_next;
      code_reg <= code_next;
    end
  end

  assign tone_valid = (st_reg != TRA_T_IDLE);
  assign tone_attn  = (st_reg == TRA_T_ATTN);
  assign tone_code  = code_reg;
  assign busy       = (st_reg != TRA_T_IDLE);

endmodule : tra_tone
